// >>> hw/fspm_core.sv
// five-stage integer pipeline with alternating cache slots, write and read buffers
// assumes core_clk is twice the processor rate; cache arrays and bus sit outside
`timescale 1ns/1ns
module fspm_core import fspm_pkg::*; (
  input wire logic core_clk, // 2x processor clock
  input wire logic sys_rst, // synchronous reset
  output logic [31:0] cache_addr_q, // cache slot address
  output logic cache_isel_q, // 1 selects instruction array
  output logic cache_we_q, // cache slot write
  output logic [31:0] cache_wdata_q, // cache write word
  output logic cache_wpar_q, // parity of write word
  input wire logic [31:0] cache_rdata, // cache read word
  input wire logic cache_rpar, // stored parity bit
  input wire logic cache_tag_hit, // tag matched
  input wire logic isolate_en, // force cache hits
  input wire logic swap_en, // exchange cache roles
  input wire logic user_rev_en, // opposite byte order in user mode
  input wire logic parity_dis, // ignore parity
  input wire logic burst_rd_en, // burst block reads
  output logic mem_rd_req_q, // block read request
  output logic [31:0] mem_rd_addr_q, // block base address
  output logic [2:0] mem_rd_len_q, // words in block
  output logic mem_rd_burst_q, // burst form requested
  input wire logic mem_rd_ack, // request taken
  input wire logic mem_rd_valid, // read word offered
  input wire logic [31:0] mem_rd_data, // read word
  output logic mem_rd_ready, // read buffer has room
  output logic mem_wr_valid, // buffered store offered
  output logic [31:0] mem_wr_addr, // store address
  output logic [31:0] mem_wr_data, // store data
  input wire logic mem_wr_ready, // memory took store
  output logic kernel_mode_q, // kernel mode flag
  output logic stall_q, // processor cycle did not advance
  output logic retire_q, // instruction completed pulse
  output logic parity_err_q // parity fault seen pulse
);
  logic ph_q;
  logic [31:0] pc_q, pc_d, fi_q, epc_q;
  logic if_ok_q, fill_slot_q, st_slot_q;
  logic fd_valid_q;
  logic [31:0] fd_instr_q, fd_pc_q;
  logic de_valid_q, de_we_q;
  logic [5:0] de_op_q, de_fn_q;
  logic [4:0] de_rs_q, de_rt_q, de_dst_q;
  logic [15:0] de_imm_q;
  logic [31:0] de_pc_q;
  logic em_valid_q, em_ld_q, em_st_q, em_we_q;
  logic [4:0] em_dst_q;
  logic [31:0] em_res_q, em_sdata_q;
  logic mw_valid_q, mw_we_q;
  logic [4:0] mw_dst_q;
  logic [31:0] mw_res_q;
  logic [31:0] rf_a, rf_b, op_a, op_b, alu_res, ld_data;
  logic [5:0] id_op;
  logic [4:0] id_rs, id_rt, id_dst;
  logic id_we, rev, hit, fetch_hit, ld_hit, mem_acc, mem_ok, adv, lu_stall;
  logic ex_trap, ex_eret, redirect;
  fspm_refill_t rf_st_q;
  logic fill_i_q;
  logic [31:0] fill_base_q, fill_addr;
  logic [2:0] fill_cnt_q;
  logic fill_go, rb_valid, rb_pop, wb_ready, wb_push;
  logic [31:0] rb_data;

  // decode of the instruction in the decode stage
  assign id_op = fd_instr_q[F_OP_LSB +: 6];
  assign id_rs = fd_instr_q[F_RS_LSB +: 5];
  assign id_rt = fd_instr_q[F_RT_LSB +: 5];
  assign id_dst = (id_op == OP_ALU) ? fd_instr_q[F_RD_LSB +: 5] : id_rt;
  assign id_we = (id_op == OP_ALU) || (id_op == OP_ADDI) || (id_op == OP_ORI) ||
                 (id_op == OP_LOAD);

  // register file read in decode, re-read for execute while held; written in first half
  fspm_regfile u_rf (
    .clk(core_clk),
    .we(!ph_q && mw_valid_q && mw_we_q && mw_dst_q != 5'h00),
    .waddr(mw_dst_q),
    .wdata(mw_res_q),
    .raddr_a(adv ? id_rs : de_rs_q),
    .raddr_b(adv ? id_rt : de_rt_q),
    .rdata_a_q(rf_a),
    .rdata_b_q(rf_b)
  );

  // hazards, hit checks and the advance decision
  assign rev = user_rev_en && !kernel_mode_q;
  assign hit = fspm_hit(cache_tag_hit, cache_rdata, cache_rpar, isolate_en, parity_dis);
  assign fetch_hit = hit;
  assign ld_hit = hit;
  assign ld_data = rev ? fspm_bswap(cache_rdata) : cache_rdata;
  assign mem_acc = em_valid_q && (em_ld_q || em_st_q);
  assign mem_ok = !mem_acc || (!fill_slot_q && (em_st_q ? st_slot_q : ld_hit));
  assign adv = ph_q && if_ok_q && mem_ok;
  assign lu_stall = de_valid_q && de_op_q == OP_LOAD && fd_valid_q &&
                    (de_dst_q == id_rs || de_dst_q == id_rt);
  assign ex_trap = de_valid_q && de_op_q == OP_TRAP;
  assign ex_eret = de_valid_q && de_op_q == OP_ERET;
  assign redirect = ex_trap || ex_eret;
  assign pc_d = !adv ? pc_q : ex_trap ? EXC_VEC : ex_eret ? epc_q :
                lu_stall ? pc_q : pc_q + PC_STEP;

  // forwarding and the execute operation
  always_comb begin
    op_a = de_a_sel(de_rs_q, rf_a);
    op_b = de_a_sel(de_rt_q, rf_b);
    alu_res = 32'h0;
    if (de_op_q == OP_ALU) begin
      case (de_fn_q)
        FN_ADD: alu_res = op_a + op_b;
        FN_SUB: alu_res = op_a - op_b;
        FN_AND: alu_res = op_a & op_b;
        FN_OR: alu_res = op_a | op_b;
        FN_XOR: alu_res = op_a ^ op_b;
        FN_SLT: alu_res = {31'h0, $signed(op_a) < $signed(op_b)};
        default: alu_res = 32'h0;
      endcase
    end else if (de_op_q == OP_ORI) begin
      alu_res = op_a | {16'h0, de_imm_q};
    end else begin
      alu_res = op_a + {{16{de_imm_q[15]}}, de_imm_q};
    end
  end

  // operand from a younger result still in flight, else the register file
  function automatic logic [31:0] de_a_sel(input logic [4:0] r, input logic [31:0] v);
    if (r == 5'h00) return 32'h0;
    if (em_valid_q && em_we_q && !em_ld_q && em_dst_q == r) return em_res_q;
    if (mw_valid_q && mw_we_q && mw_dst_q == r) return mw_res_q;
    return v;
  endfunction : de_a_sel

  // half-cycle phase: low slot instruction cache, high slot data cache
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= !ph_q;
    end
  end

  // fetch: program counter and the word read in the instruction slot
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_q <= RESET_PC;
      fi_q <= 32'h0;
      if_ok_q <= 1'b0;
    end else if (!ph_q) begin
      fi_q <= cache_rdata;
      if_ok_q <= fetch_hit;
    end else begin
      pc_q <= pc_d;
    end
  end

  // fetch to decode and decode to execute registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fd_valid_q <= 1'b0;
      fd_instr_q <= 32'h0;
      fd_pc_q <= 32'h0;
      de_valid_q <= 1'b0;
      de_we_q <= 1'b0;
      de_op_q <= OP_ALU;
      de_fn_q <= FN_ADD;
      de_rs_q <= 5'h00;
      de_rt_q <= 5'h00;
      de_dst_q <= 5'h00;
      de_imm_q <= 16'h0;
      de_pc_q <= 32'h0;
    end else if (adv) begin
      if (redirect) begin
        fd_valid_q <= 1'b0;
      end else if (!lu_stall) begin
        fd_valid_q <= 1'b1;
        fd_instr_q <= fi_q;
        fd_pc_q <= pc_q;
      end
      de_valid_q <= fd_valid_q && !redirect && !lu_stall;
      de_we_q <= id_we;
      de_op_q <= id_op;
      de_fn_q <= fd_instr_q[F_FN_LSB +: 6];
      de_rs_q <= id_rs;
      de_rt_q <= id_rt;
      de_dst_q <= id_dst;
      de_imm_q <= fd_instr_q[F_IMM_LSB +: 16];
      de_pc_q <= fd_pc_q;
    end
  end

  // execute to memory and memory to writeback registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      em_valid_q <= 1'b0;
      em_ld_q <= 1'b0;
      em_st_q <= 1'b0;
      em_we_q <= 1'b0;
      em_dst_q <= 5'h00;
      em_res_q <= 32'h0;
      em_sdata_q <= 32'h0;
      mw_valid_q <= 1'b0;
      mw_we_q <= 1'b0;
      mw_dst_q <= 5'h00;
      mw_res_q <= 32'h0;
    end else if (adv) begin
      em_valid_q <= de_valid_q && !redirect;
      em_ld_q <= de_op_q == OP_LOAD;
      em_st_q <= de_op_q == OP_STORE;
      em_we_q <= de_we_q;
      em_dst_q <= de_dst_q;
      em_res_q <= alu_res;
      em_sdata_q <= rev ? fspm_bswap(op_b) : op_b;
      mw_valid_q <= em_valid_q;
      mw_we_q <= em_we_q;
      mw_dst_q <= em_dst_q;
      mw_res_q <= em_ld_q ? ld_data : em_res_q;
    end
  end

  // kernel mode entered on exception, left on exception return
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      kernel_mode_q <= 1'b1;
      epc_q <= RESET_PC;
    end else if (adv && ex_trap) begin
      kernel_mode_q <= 1'b1;
      epc_q <= de_pc_q + PC_STEP;
    end else if (adv && ex_eret) begin
      kernel_mode_q <= 1'b0;
    end
  end

  // cache port: instruction slot, then refill write, load or store slot
  assign fill_go = (rf_st_q == FSPM_RF_FILL) && rb_valid;
  assign fill_addr = fill_base_q + {27'h0, fill_cnt_q, 2'b00};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cache_addr_q <= RESET_PC;
      cache_isel_q <= 1'b1;
      cache_we_q <= 1'b0;
      cache_wdata_q <= 32'h0;
      cache_wpar_q <= 1'b0;
      fill_slot_q <= 1'b0;
      st_slot_q <= 1'b0;
    end else if (ph_q) begin
      cache_addr_q <= pc_d;
      cache_isel_q <= !swap_en;
      cache_we_q <= 1'b0;
      fill_slot_q <= 1'b0;
      st_slot_q <= 1'b0;
    end else if (fill_go) begin
      cache_addr_q <= fill_addr;
      cache_isel_q <= fill_i_q ^ swap_en;
      cache_we_q <= 1'b1;
      cache_wdata_q <= rb_data;
      cache_wpar_q <= ^rb_data;
      fill_slot_q <= 1'b1;
    end else begin
      cache_addr_q <= em_res_q;
      cache_isel_q <= swap_en;
      cache_we_q <= mem_acc && em_st_q && wb_ready;
      cache_wdata_q <= em_sdata_q;
      cache_wpar_q <= ^em_sdata_q;
      st_slot_q <= mem_acc && em_st_q && wb_ready;
    end
  end

  // refill sequencer: wait for stores to drain, request, write block words
  assign rb_pop = ph_q && fill_slot_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rf_st_q <= FSPM_RF_IDLE;
      fill_i_q <= 1'b0;
      fill_base_q <= 32'h0;
      fill_cnt_q <= 3'h0;
      mem_rd_req_q <= 1'b0;
      mem_rd_addr_q <= 32'h0;
      mem_rd_len_q <= 3'h0;
      mem_rd_burst_q <= 1'b0;
    end else begin
      unique case (rf_st_q)
        FSPM_RF_IDLE: begin
          fill_cnt_q <= 3'h0;
          if (!ph_q && !fetch_hit) begin
            rf_st_q <= FSPM_RF_WAITWB;
            fill_i_q <= 1'b1;
            fill_base_q <= pc_q & IBLK_MASK;
            mem_rd_len_q <= IBLK_WORDS;
          end else if (ph_q && mem_acc && em_ld_q && !fill_slot_q && !ld_hit) begin
            rf_st_q <= FSPM_RF_WAITWB;
            fill_i_q <= 1'b0;
            fill_base_q <= em_res_q & WORD_MASK;
            mem_rd_len_q <= DBLK_WORDS;
          end
        end
        FSPM_RF_WAITWB: begin
          if (!mem_wr_valid) begin
            rf_st_q <= FSPM_RF_REQ;
            mem_rd_req_q <= 1'b1;
            mem_rd_addr_q <= fill_base_q;
            mem_rd_burst_q <= burst_rd_en;
          end
        end
        FSPM_RF_REQ: begin
          if (mem_rd_ack) begin
            rf_st_q <= FSPM_RF_FILL;
            mem_rd_req_q <= 1'b0;
          end
        end
        FSPM_RF_FILL: begin
          if (rb_pop) begin
            fill_cnt_q <= fill_cnt_q + 3'h1;
            if (fill_cnt_q + 3'h1 == mem_rd_len_q) begin
              rf_st_q <= FSPM_RF_IDLE;
            end
          end
        end
      endcase
    end
  end

  // read buffer between memory and refill writes
  fspm_fifo4 #(.W(32)) u_rbuf (
    .clk(core_clk),
    .rst(sys_rst),
    .in_valid(mem_rd_valid),
    .in_data(mem_rd_data),
    .in_ready_q(mem_rd_ready),
    .out_valid_q(rb_valid),
    .out_data_q(rb_data),
    .out_pop(rb_pop)
  );

  // write buffer: one push per store that leaves the memory stage
  assign wb_push = adv && st_slot_q;
  fspm_fifo4 #(.W(64)) u_wbuf (
    .clk(core_clk),
    .rst(sys_rst),
    .in_valid(wb_push),
    .in_data({cache_addr_q, cache_wdata_q}),
    .in_ready_q(wb_ready),
    .out_valid_q(mem_wr_valid),
    .out_data_q({mem_wr_addr, mem_wr_data}),
    .out_pop(mem_wr_ready)
  );

  // status pulses
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stall_q <= 1'b0;
      retire_q <= 1'b0;
      parity_err_q <= 1'b0;
    end else begin
      stall_q <= ph_q && !adv;
      retire_q <= adv && em_valid_q;
      parity_err_q <= !parity_dis && !isolate_en && cache_tag_hit && !cache_we_q &&
                      ((^cache_rdata) != cache_rpar);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_fetch_slot;
    (!ph_q && !$past(sys_rst)) |-> (!cache_we_q && cache_addr_q == pc_q);
  endproperty
  a_fetch_slot: assert property (p_fetch_slot) else $error("fetch slot not at pc");

  property p_swap_roles;
    (!ph_q && !$past(sys_rst)) |-> (cache_isel_q == !$past(swap_en));
  endproperty
  a_swap_roles: assert property (p_swap_roles) else $error("fetch used wrong array");

  property p_data_slot;
    (ph_q && mem_acc && !fill_slot_q) |-> (cache_addr_q == em_res_q && cache_isel_q == $past(swap_en));
  endproperty
  a_data_slot: assert property (p_data_slot) else $error("data slot wrong");

  property p_wbuf_full_stall;
    (ph_q && mem_acc && em_st_q && !st_slot_q) |-> !adv ##1 (stall_q && !retire_q);
  endproperty
  a_wbuf_full_stall: assert property (p_wbuf_full_stall) else $error("store passed full buffer");

  property p_store_to_mem;
    wb_push |=> mem_wr_valid;
  endproperty
  a_store_to_mem: assert property (p_store_to_mem) else $error("store not queued");

  property p_enter_kernel;
    (adv && ex_trap) |=> (kernel_mode_q && pc_q == EXC_VEC);
  endproperty
  a_enter_kernel: assert property (p_enter_kernel) else $error("trap did not enter kernel");

  property p_isolate_hit;
    (!ph_q && isolate_en) |=> if_ok_q ##1 if_ok_q;
  endproperty
  a_isolate_hit: assert property (p_isolate_hit) else $error("isolate missed");

  property p_miss_stall;
    (!ph_q && !fetch_hit) |=> (!adv ##1 stall_q);
  endproperty
  a_miss_stall: assert property (p_miss_stall) else $error("advanced past a miss");

  c_advance: cover property (adv ##2 adv);
  c_irefill: cover property (rf_st_q == FSPM_RF_FILL && fill_i_q ##[1:40] rf_st_q == FSPM_RF_IDLE);
  c_trap: cover property (adv && ex_trap);
  c_wbuf_full: cover property (!wb_ready && mem_acc && em_st_q);

endmodule : fspm_core

// >>> hw/fspm_pkg.sv
// constants, state codes and helper functions for the five-stage core
// assumes a single 50 MHz clock domain and a synchronous active-high reset
package fspm_pkg;

  // program counter values after reset and on an exception
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] EXC_VEC = 32'h0000_0080;
  localparam logic [31:0] PC_STEP = 32'h0000_0004;
  localparam logic [31:0] IBLK_MASK = 32'hFFFF_FFF0;
  localparam logic [31:0] WORD_MASK = 32'hFFFF_FFFC;

  // buffer depth and refill lengths in words
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL = 3'h4;
  localparam logic [2:0] IBLK_WORDS = 3'h4;
  localparam logic [2:0] DBLK_WORDS = 3'h1;

  // instruction field positions
  localparam int F_OP_LSB = 26;
  localparam int F_RS_LSB = 21;
  localparam int F_RT_LSB = 16;
  localparam int F_RD_LSB = 11;
  localparam int F_FN_LSB = 0;
  localparam int F_IMM_LSB = 0;

  // opcodes
  localparam logic [5:0] OP_ALU = 6'h00;
  localparam logic [5:0] OP_ADDI = 6'h01;
  localparam logic [5:0] OP_ORI = 6'h02;
  localparam logic [5:0] OP_LOAD = 6'h03;
  localparam logic [5:0] OP_STORE = 6'h04;
  localparam logic [5:0] OP_TRAP = 6'h05;
  localparam logic [5:0] OP_ERET = 6'h06;

  // register-register function codes
  localparam logic [5:0] FN_ADD = 6'h00;
  localparam logic [5:0] FN_SUB = 6'h01;
  localparam logic [5:0] FN_AND = 6'h02;
  localparam logic [5:0] FN_OR = 6'h03;
  localparam logic [5:0] FN_XOR = 6'h04;
  localparam logic [5:0] FN_SLT = 6'h05;

  // refill sequencer states
  typedef enum logic [3:0] {
    FSPM_RF_IDLE = 4'b0001,
    FSPM_RF_WAITWB = 4'b0010,
    FSPM_RF_REQ = 4'b0100,
    FSPM_RF_FILL = 4'b1000
  } fspm_refill_t;

  // swap byte order of a word
  function automatic logic [31:0] fspm_bswap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : fspm_bswap

  // cache hit: forced by isolate, else tag match with good or ignored parity
  function automatic logic fspm_hit(input logic tag_hit, input logic [31:0] d,
                                    input logic par, input logic iso, input logic pdis);
    return iso | (tag_hit & (pdis | ((^d) == par)));
  endfunction : fspm_hit

endpackage : fspm_pkg

// >>> hw/fspm_fifo4.sv
// four-entry shift-register fifo; head entry and flags come from flops
// pushes and pops are qualified inside by in_ready_q and out_valid_q, not by the caller
`timescale 1ns/1ns
module fspm_fifo4 import fspm_pkg::*; #(
  parameter int W = 32
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic in_valid, // offer an entry
  input wire logic [W-1:0] in_data, // entry offered
  output logic in_ready_q, // room for one more
  output logic out_valid_q, // head entry present
  output logic [W-1:0] out_data_q, // head entry
  input wire logic out_pop // consume the head
);
  logic [W-1:0] ent_q [FIFO_DEPTH];
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic push;
  logic pop;

  // qualified handshakes and next fill level
  assign push = in_valid & in_ready_q;
  assign pop = out_pop & out_valid_q;
  assign cnt_d = cnt_q + {2'b00, push} - {2'b00, pop};
  assign out_data_q = ent_q[0];

  // level and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 3'h0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != FIFO_FULL);
      out_valid_q <= (cnt_d != 3'h0);
    end
  end

  // entries shift toward the head on a pop
  always_ff @(posedge clk) begin
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      if (pop) begin
        if (push && (3'(i) == cnt_q - 3'h1)) begin
          ent_q[i] <= in_data;
        end else if (i < FIFO_DEPTH - 1) begin
          ent_q[i] <= ent_q[(i + 1) % FIFO_DEPTH];
        end
      end else if (push && (3'(i) == cnt_q)) begin
        ent_q[i] <= in_data;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fifo_bound;
    cnt_q <= FIFO_FULL && (in_ready_q == (cnt_q != FIFO_FULL));
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo level or ready wrong");

  property p_fifo_fill;
    (push && !pop) |=> out_valid_q;
  endproperty
  a_fifo_fill: assert property (p_fifo_fill) else $error("pushed entry not visible");

endmodule : fspm_fifo4

// >>> hw/fspm_regfile.sv
// 32 x 32 general register file, two registered read ports, one write port
// assumes register zero reads as zero; a same-edge write is bypassed to reads
`timescale 1ns/1ns
module fspm_regfile (
  input wire logic clk, // core clock
  input wire logic we, // write enable
  input wire logic [4:0] waddr, // write index
  input wire logic [31:0] wdata, // write value
  input wire logic [4:0] raddr_a, // first read index
  input wire logic [4:0] raddr_b, // second read index
  output logic [31:0] rdata_a_q, // first read value
  output logic [31:0] rdata_b_q // second read value
);
  logic [31:0] mem_q [32];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // registered reads with write bypass
  always_ff @(posedge clk) begin
    rdata_a_q <= (raddr_a == 5'h00) ? 32'h0 :
                 (we && waddr == raddr_a) ? wdata : mem_q[raddr_a];
    rdata_b_q <= (raddr_b == 5'h00) ? 32'h0 :
                 (we && waddr == raddr_b) ? wdata : mem_q[raddr_b];
  end

endmodule : fspm_regfile

// >>> tb/fspm_mem_model.sv
// main memory behind the bus unit, plus the cache arrays facing the core
// assumes the bench fills mem and reads the store log wlog_a / wlog_d
`timescale 1ns/1ns
module fspm_mem_model import fspm_pkg::*; (
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // clears cache valid bits
  input wire logic wr_stall, // hold off store pops
  input wire logic [31:0] cache_addr_q, // slot address
  input wire logic cache_isel_q, // array select
  input wire logic cache_we_q, // slot write
  input wire logic [31:0] cache_wdata_q, // write word
  input wire logic cache_wpar_q, // write parity
  output logic [31:0] cache_rdata, // read word
  output logic cache_rpar, // stored parity
  output logic cache_tag_hit, // tag match
  input wire logic mem_rd_req_q, // block request
  input wire logic [31:0] mem_rd_addr_q, // block base
  input wire logic [2:0] mem_rd_len_q, // words wanted
  output logic mem_rd_ack = 1'b0, // request taken
  output logic mem_rd_valid, // word offered
  output logic [31:0] mem_rd_data, // word
  input wire logic mem_rd_ready, // room in read buffer
  input wire logic mem_wr_valid, // store offered
  input wire logic [31:0] mem_wr_addr, // store address
  input wire logic [31:0] mem_wr_data, // store data
  output logic mem_wr_ready // store taken
);
  logic [31:0] mem [64];
  logic [31:0] cd [128];
  logic [31:0] ct [128];
  logic [127:0] cv = '0;
  logic [127:0] cp = '0;
  logic [31:0] rd_a = 32'h0000_0000;
  logic [2:0] rd_cnt = 3'h0;
  logic [31:0] wlog_a [$];
  logic [31:0] wlog_d [$];
  logic [6:0] ix;
  // both arrays share one port, split by the select bit
  assign ix = {cache_isel_q, cache_addr_q[7:2]};
  assign cache_rdata = cd[ix];
  assign cache_rpar = cp[ix];
  assign cache_tag_hit = cv[ix] && ct[ix] == cache_addr_q;
  // words go out in address order; an idle bus shows the inverse
  assign mem_rd_valid = rd_cnt != 3'h0;
  assign mem_rd_data = mem_rd_valid ? mem[rd_a[7:2]] : ~mem[rd_a[7:2]];
  assign mem_wr_ready = !wr_stall;
  // cache writes, read sequencing and the store log
  always @(posedge core_clk) begin
    mem_rd_ack <= 1'b0;
    if (sys_rst) begin
      cv <= '0;
      rd_cnt <= 3'h0;
    end else if (mem_rd_req_q && !mem_rd_ack && !mem_rd_valid) begin
      mem_rd_ack <= 1'b1;
      rd_a <= mem_rd_addr_q;
      rd_cnt <= mem_rd_len_q;
    end else if (mem_rd_valid && mem_rd_ready) begin
      rd_a <= rd_a + 32'h0000_0004;
      rd_cnt <= rd_cnt - 3'h1;
    end
    if (cache_we_q) begin
      cv[ix] <= 1'b1;
      cd[ix] <= cache_wdata_q;
      ct[ix] <= cache_addr_q;
      cp[ix] <= cache_wpar_q;
    end
    if (mem_wr_valid && mem_wr_ready) begin
      wlog_a.push_back(mem_wr_addr);
      wlog_d.push_back(mem_wr_data);
    end
  end
endmodule : fspm_mem_model

// >>> tb/tb.sv
// self-checking bench for the five-stage core against the memory model
// assumes programs are loaded into the model while reset is held
`timescale 1ns/1ns
module tb import fspm_pkg::*; ();
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic iso = 1'b0, swp = 1'b0, rev = 1'b0, pdis = 1'b0, burst = 1'b0, stl = 1'b0;
  logic [31:0] cache_addr_q, cache_wdata_q, cache_rdata, mem_rd_addr_q, mem_rd_data;
  logic [31:0] mem_wr_addr, mem_wr_data;
  logic [2:0] mem_rd_len_q;
  logic cache_isel_q, cache_we_q, cache_wpar_q, cache_rpar, cache_tag_hit, mem_rd_req_q;
  logic mem_rd_burst_q, mem_rd_ack, mem_rd_valid, mem_rd_ready, mem_wr_valid, mem_wr_ready;
  logic kernel_mode_q, stall_q, retire_q, parity_err_q;
  integer mismatches = 0, checks_done = 0, n;
  integer perr = 0, nret = 0;
  // rows: function code, expected result of 5 op 7
  logic [37:0] rows [6] = '{{FN_ADD, 32'h0000_000C}, {FN_SUB, 32'hFFFF_FFFE},
    {FN_AND, 32'h0000_0005}, {FN_OR, 32'h0000_0007}, {FN_XOR, 32'h0000_0002},
    {FN_SLT, 32'h0000_0001}};
  fspm_core i_dut (.core_clk, .sys_rst, .cache_addr_q, .cache_isel_q, .cache_we_q,
    .cache_wdata_q, .cache_wpar_q, .cache_rdata, .cache_rpar, .cache_tag_hit,
    .isolate_en(iso), .swap_en(swp), .user_rev_en(rev), .parity_dis(pdis),
    .burst_rd_en(burst), .mem_rd_req_q, .mem_rd_addr_q, .mem_rd_len_q, .mem_rd_burst_q,
    .mem_rd_ack, .mem_rd_valid, .mem_rd_data, .mem_rd_ready, .mem_wr_valid, .mem_wr_addr,
    .mem_wr_data, .mem_wr_ready, .kernel_mode_q, .stall_q, .retire_q, .parity_err_q);
  fspm_mem_model i_mem (.core_clk, .sys_rst, .wr_stall(stl), .cache_addr_q, .cache_isel_q,
    .cache_we_q, .cache_wdata_q, .cache_wpar_q, .cache_rdata, .cache_rpar, .cache_tag_hit,
    .mem_rd_req_q, .mem_rd_addr_q, .mem_rd_len_q, .mem_rd_ack, .mem_rd_valid, .mem_rd_data,
    .mem_rd_ready, .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .mem_wr_ready);
  always #10 core_clk = ~core_clk;
  // parity faults and retirements seen over the whole run
  always @(negedge core_clk) begin
    perr += parity_err_q;
    nret += retire_q;
  end
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // hold reset, fill memory with no-ops, clear the store log
  task automatic prep();
    @(negedge core_clk);
    sys_rst = 1'b1;
    foreach (i_mem.mem[k]) i_mem.mem[k] = 32'hFC00_0000;
    i_mem.wlog_a.delete();
    i_mem.wlog_d.delete();
  endtask : prep
  task automatic go();
    repeat (10) @(negedge core_clk);
    check({29'h0, mem_wr_valid, kernel_mode_q, mem_rd_ready}, 32'h0000_0003);
    sys_rst = 1'b0;
  endtask : go
  task automatic wait_log(input int cnt);
    for (int k = 0; k < 3000 && i_mem.wlog_a.size() < cnt; k++) @(negedge core_clk);
    check(32'(i_mem.wlog_a.size()), 32'(cnt));
  endtask : wait_log
  // longest test needs a few hundred cycles; allow far more
  initial begin
    #400_000;
    mismatches++;
    stop_test();
  end
  initial begin
    for (int r = 0; r < 6; r++) begin
      prep();
      burst = r[0];
      pdis = r[1];
      i_mem.mem[0] = {OP_ADDI, 5'h00, 5'h01, 16'h0005};
      i_mem.mem[1] = {OP_ADDI, 5'h00, 5'h02, 16'h0007};
      i_mem.mem[5] = {OP_ALU, 5'h01, 5'h02, 5'h03, 5'h00, rows[r][37:32]};
      i_mem.mem[9] = {OP_STORE, 5'h00, 5'h03, 16'h00C0};
      i_mem.mem[10] = {OP_LOAD, 5'h00, 5'h04, 16'h00D0};
      i_mem.mem[11] = {OP_LOAD, 5'h00, 5'h05, 16'h00C0};
      i_mem.mem[12] = {OP_STORE, 5'h00, 5'h04, 16'h00C4};
      i_mem.mem[13] = {OP_STORE, 5'h00, 5'h05, 16'h00C8};
      go();
      wait_log(3);
      check(i_mem.wlog_d[0], rows[r][31:0]);
      check(i_mem.wlog_a[0], 32'h0000_00C0);
      check(i_mem.wlog_d[1], 32'hFC00_0000);
      check(i_mem.wlog_d[2], rows[r][31:0]);
      check({31'h0, mem_rd_burst_q}, 32'(r[0]));
      $display("alu row %0d done", r);
    end
    // trap in kernel, return to user mode, store with reversed bytes
    prep();
    rev = 1'b1;
    i_mem.mem[0] = {OP_TRAP, 26'h0};
    i_mem.mem[32] = {OP_ERET, 26'h0};
    i_mem.mem[4] = {OP_ADDI, 5'h00, 5'h01, 16'h1234};
    i_mem.mem[8] = {OP_STORE, 5'h00, 5'h01, 16'h00C0};
    go();
    for (n = 0; n < 800 && kernel_mode_q !== 1'b0; n++) @(negedge core_clk);
    check({31'h0, kernel_mode_q}, 32'h0000_0000);
    wait_log(1);
    check(i_mem.wlog_d[0], 32'h3412_0000);
    rev = 1'b0;
    $display("mode and byte order test done");
    // memory refuses stores: eight stores fill the buffer and wait, then drain in order
    prep();
    stl = 1'b1;
    for (int k = 0; k < 8; k++) i_mem.mem[k] = {OP_STORE, 5'h00, 5'h00, 16'(8'hC0 + 4 * k)};
    go();
    // both arrays preloaded so no refill; swapped and isolated while blocked
    for (int k = 0; k < 16; k++) begin
      n = 64 * k[3] + k[2:0];
      i_mem.cd[n] = i_mem.mem[k[2:0]];
      i_mem.ct[n] = 32'(4 * k[2:0]);
      i_mem.cp[n] = ^i_mem.mem[k[2:0]];
      i_mem.cv[n] = 1'b1;
    end
    iso = 1'b1;
    swp = 1'b1;
    n = 0;
    repeat (300) @(negedge core_clk) n += stall_q;
    check(32'(n > 0), 32'h0000_0001);
    check({31'h0, mem_wr_valid}, 32'h0000_0001);
    stl = 1'b0;
    iso = 1'b0;
    swp = 1'b0;
    wait_log(8);
    for (int k = 0; k < 8; k++) check(i_mem.wlog_a[k], 32'(8'hC0 + 4 * k));
    $display("write buffer test done");
    check(perr, 32'h0000_0000);
    check(32'(nret > 0), 32'h0000_0001);
    stop_test();
  end
endmodule : tb
